//--- rtl/ect_pkg.sv
// ect_pkg: constants for the event counter timer bank
// assumes: single 10 MHz clock, plain port control (no register bus)
package ect_pkg;
  // ==========================================================
  // sizes
  localparam int CNT_W    = 16;
  localparam int N_CH     = 5;
  localparam int CH_W     = 3;
  // ==========================================================
  // mode field (two lowest bits of the mode setting)
  localparam logic [1:0] MODE_TIMER   = 2'h0;
  localparam logic [1:0] MODE_EVENT   = 2'h1;
  localparam logic [1:0] MODE_ONESHOT = 2'h2;
  localparam logic [1:0] MODE_PWM     = 2'h3;
  // ==========================================================
  // count source select
  localparam logic [1:0] SRC_PIN     = 2'h0;
  localparam logic [1:0] SRC_BTIMER  = 2'h1;
  localparam logic [1:0] SRC_SIBLING = 2'h2;
  // ==========================================================
  // output pin use
  localparam logic [1:0] OUT_PORT  = 2'h0;
  localparam logic [1:0] OUT_PULSE = 2'h1;
  localparam logic [1:0] OUT_DIRIN = 2'h2;
  // ==========================================================
  // channel roles and reset values
  localparam logic [CH_W-1:0]  CH_NORMAL_ONLY = 3'h2;
  localparam logic [CH_W-1:0]  CH_SELECTABLE  = 3'h3;
  localparam logic [CH_W-1:0]  CH_X4_ONLY     = 3'h4;
  localparam logic [CH_W-1:0]  CH_FIRST_2PH   = 3'h2;
  localparam logic [CNT_W-1:0] CNT_RST        = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX        = 16'hFFFF;
endpackage

//--- rtl/ect_sync.sv
// ect_sync: two-flop synchroniser with registered edge detection
// assumes: input may change at any time relative to ref_clk
`timescale 1ns/100ps
module ect_sync
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic async_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= 1'h0;
      sync_r <= 1'h0;
      prev_r <= 1'h0;
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise  = sync_r & ~prev_r;
  assign fall  = ~sync_r & prev_r;
endmodule

//--- rtl/ect_channel.sv
// ect_channel: one A-type timer channel in event counter mode
// assumes: pins and controls synchronous to ref_clk except the two
// event pins, which are synchronised here; software drives the
// control ports directly.
// How it works
// - channels 0,1 single-phase only; 2-4 also two-phase
// - source: input pin edge or timer overflow
// - direction from output pin level or software
// - wrap reloads from reload register unless free-run
// - ratios 1/(FFFF-n+1) up, 1/(n+1) down
// - counts only while start flag is one
// - interrupt request on every wrap
// - read returns live count value
// - stopped write loads reload and counter
// - running write loads reload only
// - free-run wraps without reload
// - pulse option toggles output pin on wrap
// - output pin: port, pulse, or direction input
// - two-phase counts using both pins' phase
// - normal: up on rise, down on fall, out high
// - x4: every edge counts, direction by phase
// - ch3 selectable; ch2 normal; ch4 x4
// - mode field's two low bits select event mode
`timescale 1ns/100ps
module ect_channel
#(
  parameter logic [2:0] CH_ID = 3'h0,
  parameter int         W     = 16
)
(
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [1:0]   mode_sel,
  input  wire logic         start_flag,
  input  wire logic [1:0]   src_sel,
  input  wire logic         edge_fall,
  input  wire logic [1:0]   out_use,
  input  wire logic         sw_down,
  input  wire logic         free_run,
  input  wire logic         two_phase,
  input  wire logic         x4_sel,
  input  wire logic         port_out_val,
  input  wire logic         second_b_timer_ovf,
  input  wire logic         sibling_a_timer_ovf,
  input  wire logic [W-1:0] wr_data,
  input  wire logic         wr_stb,
  input  wire logic         event_input_pin,
  input  wire logic         event_output_pin_in,
  output logic              event_output_pin_out,
  output logic              event_output_pin_oe,
  output logic [W-1:0]      count_value,
  output logic [W-1:0]      reload_value,
  output logic              wrap_pulse,
  output logic              irq_req
);
  // ==========================================================
  // pin synchronisers
  logic in_lvl;
  logic in_rise;
  logic in_fall;
  logic out_lvl;
  logic out_rise;
  logic out_fall;

  ect_sync u_sync_in
  (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (event_input_pin),
    .level    (in_lvl),
    .rise     (in_rise),
    .fall     (in_fall)
  );

  ect_sync u_sync_out
  (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (event_output_pin_in),
    .level    (out_lvl),
    .rise     (out_rise),
    .fall     (out_fall)
  );

  // ==========================================================
  // channel capabilities
  localparam bit CAN_2PH = (CH_ID >= ect_pkg::CH_FIRST_2PH);
  localparam bit IS_SEL  = (CH_ID == ect_pkg::CH_SELECTABLE);
  localparam bit IS_X4   = (CH_ID == ect_pkg::CH_X4_ONLY);

  wire event_mode = (mode_sel == ect_pkg::MODE_EVENT);
  wire run        = event_mode & start_flag;
  wire tp_on      = CAN_2PH & two_phase;
  wire x4_on      = tp_on & (IS_X4 | (IS_SEL & x4_sel));

  // ==========================================================
  // single-phase step
  wire pin_edge = edge_fall ? in_fall : in_rise;
  wire sp_step  = (src_sel == ect_pkg::SRC_PIN)     ? pin_edge :
                  (src_sel == ect_pkg::SRC_BTIMER)  ? second_b_timer_ovf :
                  (src_sel == ect_pkg::SRC_SIBLING) ? sibling_a_timer_ovf :
                  1'h0;
  wire dir_pin  = (out_use == ect_pkg::OUT_DIRIN);
  wire sp_down  = dir_pin ? ~out_lvl : sw_down;

  // ==========================================================
  // two-phase step
  wire nrm_up   = out_lvl & in_rise;
  wire nrm_dn   = out_lvl & in_fall;
  wire x4_up    = (in_rise & out_lvl) | (in_fall & ~out_lvl) |
                  (out_rise & ~in_lvl) | (out_fall & in_lvl);
  wire x4_dn    = (in_fall & out_lvl) | (in_rise & ~out_lvl) |
                  (out_rise & in_lvl) | (out_fall & ~in_lvl);
  wire tp_up    = x4_on ? x4_up : nrm_up;
  wire tp_dn    = x4_on ? x4_dn : nrm_dn;

  wire step     = tp_on ? (tp_up ^ tp_dn) : sp_step;
  wire down     = tp_on ? tp_dn : sp_down;

  // ==========================================================
  // counter datapath
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic [W-1:0] rld_r;
  logic         tog_r;
  logic         wrap_r;

  wire [W-1:0] all_ones = {W{1'b1}};
  wire         at_top   = (cnt_r == all_ones);
  wire         at_zero  = (cnt_r == '0);
  wire         cnt_step = run & step;
  wire         wrap     = cnt_step & (down ? at_zero : at_top);
  wire [W-1:0] cnt_inc  = cnt_r + {{(W-1){1'b0}}, 1'b1};
  wire [W-1:0] cnt_dec  = cnt_r - {{(W-1){1'b0}}, 1'b1};

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (wr_stb && !run)
      cnt_nxt = wr_data;
    else if (wrap && !free_run)
      cnt_nxt = rld_r;
    else if (cnt_step)
      cnt_nxt = down ? cnt_dec : cnt_inc;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r  <= ect_pkg::CNT_RST;
      rld_r  <= ect_pkg::CNT_RST;
      tog_r  <= 1'h0;
      wrap_r <= 1'h0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      wrap_r <= wrap;
      if (wr_stb)
        rld_r <= wr_data;
      if (wrap && out_use == ect_pkg::OUT_PULSE)
        tog_r <= ~tog_r;
    end
  end

  // ==========================================================
  // outputs
  assign count_value  = cnt_r;
  assign reload_value = rld_r;
  assign wrap_pulse   = wrap_r;
  assign irq_req      = wrap_r;

  wire drive_pin = ~tp_on & ~dir_pin;
  assign event_output_pin_oe  = drive_pin;
  assign event_output_pin_out = (out_use == ect_pkg::OUT_PULSE) ?
                                tog_r : port_out_val;

  // ==========================================================
  // assertions
  sequence s_down_wrap;
    run && step && down && at_zero && !(wr_stb && !run);
  endsequence

  sequence s_up_wrap;
    run && step && !down && at_top;
  endsequence

  property p_reload_down;
    @(posedge ref_clk) disable iff (rst)
    s_down_wrap and !free_run |=> cnt_r == $past(rld_r);
  endproperty
  a_reload_down: assert property (p_reload_down)
    else $error("no reload after underflow");

  property p_free_run_up;
    @(posedge ref_clk) disable iff (rst)
    s_up_wrap and free_run |=> cnt_r == '0;
  endproperty
  a_free_run_up: assert property (p_free_run_up)
    else $error("free-run overflow did not wrap to zero");

  property p_irq_on_wrap;
    @(posedge ref_clk) disable iff (rst)
    (s_up_wrap or s_down_wrap) |=> irq_req;
  endproperty
  a_irq_on_wrap: assert property (p_irq_on_wrap)
    else $error("interrupt request missing on wrap");

  property p_hold_stopped;
    @(posedge ref_clk) disable iff (rst)
    !start_flag && !wr_stb |=> $stable(cnt_r);
  endproperty
  a_hold_stopped: assert property (p_hold_stopped)
    else $error("counter moved while stopped");

  property p_write_stopped;
    @(posedge ref_clk) disable iff (rst)
    wr_stb && !run |=> cnt_r == $past(wr_data) &&
                      rld_r == $past(wr_data);
  endproperty
  a_write_stopped: assert property (p_write_stopped)
    else $error("stopped write not in counter and reload");

  property p_write_running;
    @(posedge ref_clk) disable iff (rst)
    wr_stb && run && !wrap |=> rld_r == $past(wr_data) &&
      (cnt_r == $past(cnt_r) || cnt_r == $past(cnt_inc) ||
       cnt_r == $past(cnt_dec));
  endproperty
  a_write_running: assert property (p_write_running)
    else $error("running write disturbed counter");

  property p_toggle;
    @(posedge ref_clk) disable iff (rst)
    wrap && out_use == ect_pkg::OUT_PULSE |=> tog_r != $past(tog_r);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("output pin not inverted on wrap");

  property p_single_only;
    @(posedge ref_clk) disable iff (rst)
    !CAN_2PH && out_use != ect_pkg::OUT_DIRIN |-> event_output_pin_oe;
  endproperty
  a_single_only: assert property (p_single_only)
    else $error("two-phase active on single-phase channel");

  property p_normal_up;
    @(posedge ref_clk) disable iff (rst)
    run && tp_on && !x4_on && nrm_up && !at_top && !wr_stb
    |=> cnt_r == $past(cnt_inc);
  endproperty
  a_normal_up: assert property (p_normal_up)
    else $error("normal two-phase rise did not count up");

  property p_fixed_proc;
    @(posedge ref_clk) disable iff (rst)
    tp_on && !IS_X4 && !(IS_SEL && x4_sel) && !in_rise && !in_fall
    |-> !step;
  endproperty
  a_fixed_proc: assert property (p_fixed_proc)
    else $error("processing choice not fixed for channel");

  property p_mode_gate;
    @(posedge ref_clk) disable iff (rst)
    mode_sel != ect_pkg::MODE_EVENT && !wr_stb |=> $stable(cnt_r);
  endproperty
  a_mode_gate: assert property (p_mode_gate)
    else $error("counted outside event mode");

  property p_reload_up;
    @(posedge ref_clk) disable iff (rst)
    s_up_wrap and !free_run |=> cnt_r == $past(rld_r);
  endproperty
  a_reload_up: assert property (p_reload_up)
    else $error("no reload after overflow");

  property p_free_run_down;
    @(posedge ref_clk) disable iff (rst)
    s_down_wrap and free_run |=> cnt_r == all_ones;
  endproperty
  a_free_run_down: assert property (p_free_run_down)
    else $error("free-run underflow did not wrap to all ones");

  property p_irq_only_wrap;
    @(posedge ref_clk) disable iff (rst)
    !wrap |=> !irq_req;
  endproperty
  a_irq_only_wrap: assert property (p_irq_only_wrap)
    else $error("interrupt request without wrap");

  property p_toggle_hold;
    @(posedge ref_clk) disable iff (rst)
    !wrap |=> tog_r == $past(tog_r);
  endproperty
  a_toggle_hold: assert property (p_toggle_hold)
    else $error("output pin toggled without wrap");

  property p_edge_select;
    @(posedge ref_clk) disable iff (rst)
    run && !tp_on && src_sel == ect_pkg::SRC_PIN && edge_fall &&
    !in_fall |=> $stable(cnt_r);
  endproperty
  a_edge_select: assert property (p_edge_select)
    else $error("counted on the unselected pin edge");

  property p_sp_dir;
    @(posedge ref_clk) disable iff (rst)
    run && !tp_on && dir_pin && out_lvl && sp_step && !at_top
    |=> cnt_r == $past(cnt_inc);
  endproperty
  a_sp_dir: assert property (p_sp_dir)
    else $error("direction pin high did not count up");

  property p_oe_two_phase;
    @(posedge ref_clk) disable iff (rst)
    tp_on |-> !event_output_pin_oe;
  endproperty
  a_oe_two_phase: assert property (p_oe_two_phase)
    else $error("output pin driven in two-phase mode");

  property p_normal_down;
    @(posedge ref_clk) disable iff (rst)
    run && tp_on && !x4_on && nrm_dn && !at_zero
    |=> cnt_r == $past(cnt_dec);
  endproperty
  a_normal_down: assert property (p_normal_down)
    else $error("normal two-phase fall did not count down");

  property p_x4_up;
    @(posedge ref_clk) disable iff (rst)
    run && x4_on && x4_up && !x4_dn && !at_top
    |=> cnt_r == $past(cnt_inc);
  endproperty
  a_x4_up: assert property (p_x4_up)
    else $error("x4 up edge did not count up");

  property p_x4_down;
    @(posedge ref_clk) disable iff (rst)
    run && x4_on && x4_dn && !x4_up && !at_zero
    |=> cnt_r == $past(cnt_dec);
  endproperty
  a_x4_down: assert property (p_x4_down)
    else $error("x4 down edge did not count down");
endmodule

//--- tb/ect_pulse_src.sv
// ect_pulse_src: behavioural pulse and quadrature source for both pins
// assumes: the bench calls its tasks by hierarchical name and the pins
// have no phase relation to the channel clock
`timescale 1ns/100ps
module ect_pulse_src
(
  output logic in_pin,
  output logic out_pin
);
  initial
  begin
    in_pin  = 1'b0;
    out_pin = 1'b0;
  end
  // ==========================================================
  // pin drive
  // hold each level well past the synchroniser delay, whole periods
  task put(input logic i, input logic o);
    in_pin  = i;
    out_pin = o;
    #700;
  endtask
  task pulse;
    put(1'b1, out_pin);
    put(1'b0, out_pin);
  endtask
  // four edges; the output pin leads when counting up
  task quad(input logic up);
    put(!up, up);
    put(1'b1, 1'b1);
    put(up, !up);
    put(1'b0, 1'b0);
  endtask
endmodule

//--- tb/event_counter_timer_tb.sv
// event_counter_timer_tb: directed bench for one event counter channel plus a single-phase-only twin
// assumes: the channel is built as the selectable two-phase channel,
// with the pulse source model on both event pins
`timescale 1ns/100ps
module event_counter_timer_tb;
  logic        ref_clk    = 1'b0;
  logic        rst        = 1'b1;
  logic [1:0]  mode_sel   = ect_pkg::MODE_EVENT;
  logic        start_flag = 1'b0;
  logic [1:0]  src_sel    = ect_pkg::SRC_PIN;
  logic [1:0]  out_use    = ect_pkg::OUT_PULSE;
  logic        sw_down    = 1'b1;
  logic        free_run   = 1'b0;
  logic        two_phase  = 1'b0;
  logic        x4_sel     = 1'b0;
  logic        b_ovf      = 1'b0;
  logic        s_ovf      = 1'b0;
  logic [15:0] wr_data    = 16'h0000;
  logic        wr_stb     = 1'b0;
  logic [15:0] cnt;
  logic [15:0] rld;
  logic [15:0] c1;
  logic        m_in;
  logic        m_out;
  logic        pin_out;
  logic        pin_oe;
  logic        irq_req;
  logic        edge_fall  = 1'b0;
  logic        port_out_val = 1'b0;
  logic        wrap_p;
  logic        pin_out_sp;
  logic        pin_oe_sp;
  int          irq_n      = 0;
  int          wrap_n     = 0;
  int          cyc        = 0;
  int          bad_count  = 0;
  int          cmp_count  = 0;
  wire         pin_w      = pin_oe ? pin_out : m_out;
  wire         pin_w_sp   = pin_oe_sp ? pin_out_sp : m_out;

  always #50 ref_clk = ~ref_clk;

  ect_pulse_src src
  (
    .in_pin(m_in),
    .out_pin(m_out)
  );
  ect_channel #(.CH_ID(ect_pkg::CH_SELECTABLE), .W(ect_pkg::CNT_W)) dut
  (
    .ref_clk(ref_clk), .rst(rst), .mode_sel(mode_sel),
    .start_flag(start_flag), .src_sel(src_sel), .edge_fall(edge_fall),
    .out_use(out_use), .sw_down(sw_down), .free_run(free_run),
    .two_phase(two_phase), .x4_sel(x4_sel), .port_out_val(port_out_val),
    .second_b_timer_ovf(b_ovf), .sibling_a_timer_ovf(s_ovf),
    .wr_data(wr_data), .wr_stb(wr_stb), .event_input_pin(m_in),
    .event_output_pin_in(pin_w), .event_output_pin_out(pin_out),
    .event_output_pin_oe(pin_oe), .count_value(cnt),
    .reload_value(rld), .wrap_pulse(wrap_p), .irq_req(irq_req)
  );
  // single-phase-only channel on the same controls
  ect_channel #(.CH_ID(3'h0), .W(ect_pkg::CNT_W)) dut_sp
  (
    .ref_clk(ref_clk), .rst(rst), .mode_sel(mode_sel),
    .start_flag(start_flag), .src_sel(src_sel), .edge_fall(edge_fall),
    .out_use(out_use), .sw_down(sw_down), .free_run(free_run),
    .two_phase(two_phase), .x4_sel(x4_sel), .port_out_val(port_out_val),
    .second_b_timer_ovf(b_ovf), .sibling_a_timer_ovf(s_ovf),
    .wr_data(wr_data), .wr_stb(wr_stb), .event_input_pin(m_in),
    .event_output_pin_in(pin_w_sp), .event_output_pin_out(pin_out_sp),
    .event_output_pin_oe(pin_oe_sp), .count_value(),
    .reload_value(), .wrap_pulse(), .irq_req()
  );
  // ==========================================================
  // watchers
  always @(posedge ref_clk)
  begin
    if (irq_req === 1'b1)
      irq_n <= irq_n + 1;
    if (wrap_p === 1'b1)
      wrap_n <= wrap_n + 1;
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      bad_count++;
      $display("MISMATCH %0t run too long", $time);
      give_verdict;
    end
  end
  // ==========================================================
  // tasks
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #10;
  endtask
  task chk16(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t flag %b want %b", $time, got, exp);
    end
  endtask
  task wr(input logic [15:0] d);
    wr_data = d;
    wr_stb  = 1'b1;
    tick(1);
    wr_stb  = 1'b0;
    tick(1);
  endtask
  task ovf(input logic sib);
    b_ovf = !sib;
    s_ovf = sib;
    tick(1);
    b_ovf = 1'b0;
    s_ovf = 1'b0;
    tick(1);
  endtask
  task pulses(input int n);
    repeat (n) src.pulse();
    tick(1);
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==========================================================
  // tests
  initial
  begin
    tick(10);
    rst = 1'b0;
    tick(4);
    chk16(cnt, ect_pkg::CNT_RST);
    chk16(rld, ect_pkg::CNT_RST);
    $display("test reset done");
    wr(16'h0002);
    chk16(cnt, 16'h0002);
    chk16(rld, 16'h0002);
    start_flag = 1'b1;
    pulses(2);
    chk16(cnt, 16'h0000);
    pulses(1);
    chk16(cnt, 16'h0002);
    tick(2);
    chk16(16'(irq_n), 16'h0001);
    chk1(pin_out, 1'b1);
    wr(16'h0005);
    chk16(cnt, 16'h0002);
    chk16(rld, 16'h0005);
    pulses(3);
    chk16(cnt, 16'h0005);
    $display("test down reload done");
    start_flag = 1'b0;
    pulses(2);
    chk16(cnt, 16'h0005);
    start_flag = 1'b1;
    mode_sel = ect_pkg::MODE_TIMER;
    pulses(2);
    chk16(cnt, 16'h0005);
    mode_sel = ect_pkg::MODE_EVENT;
    out_use = ect_pkg::OUT_PORT;
    port_out_val = 1'b1;
    tick(1);
    chk1(pin_out, 1'b1);
    chk1(pin_oe, 1'b1);
    port_out_val = 1'b0;
    out_use = ect_pkg::OUT_PULSE;
    $display("test halt done");
    start_flag = 1'b0;
    wr(16'hFFFE);
    sw_down = 1'b0;
    free_run = 1'b1;
    src_sel = ect_pkg::SRC_BTIMER;
    start_flag = 1'b1;
    ovf(1'b0);
    chk16(cnt, 16'hFFFF);
    ovf(1'b0);
    chk16(cnt, 16'h0000);
    sw_down = 1'b1;
    ovf(1'b0);
    chk16(cnt, 16'hFFFF);
    sw_down = 1'b0;
    start_flag = 1'b0;
    free_run = 1'b0;
    src_sel = ect_pkg::SRC_SIBLING;
    wr(16'hFFFF);
    start_flag = 1'b1;
    ovf(1'b1);
    chk16(cnt, 16'hFFFF);
    tick(3);
    chk16(16'(irq_n), 16'h0005);
    chk16(16'(wrap_n), 16'h0005);
    chk1(pin_out, 1'b1);
    $display("test up count done");
    start_flag = 1'b0;
    wr(16'h0100);
    src_sel = ect_pkg::SRC_PIN;
    out_use = ect_pkg::OUT_DIRIN;
    start_flag = 1'b1;
    src.put(1'b0, 1'b1);
    chk1(pin_oe, 1'b0);
    pulses(1);
    c1 = cnt;
    src.put(1'b0, 1'b0);
    pulses(1);
    chk16(c1, 16'h0101);
    chk16(cnt, 16'h0100);
    edge_fall = 1'b1;
    src.put(1'b1, 1'b0);
    chk16(cnt, 16'h0100);
    src.put(1'b0, 1'b0);
    chk16(cnt, 16'h00FF);
    edge_fall = 1'b0;
    $display("test direction pin done");
    two_phase = 1'b1;
    out_use = ect_pkg::OUT_PULSE;
    tick(1);
    chk1(pin_oe, 1'b0);
    chk1(pin_oe_sp, 1'b1);
    src.put(1'b0, 1'b1);
    src.put(1'b1, 1'b1);
    tick(1);
    chk16(cnt, 16'h0100);
    src.put(1'b0, 1'b1);
    src.put(1'b0, 1'b0);
    src.put(1'b1, 1'b0);
    src.put(1'b0, 1'b0);
    tick(1);
    chk16(cnt, 16'h00FF);
    x4_sel = 1'b1;
    src.quad(1'b1);
    tick(1);
    chk16(cnt, 16'h0103);
    src.quad(1'b0);
    tick(1);
    chk16(cnt, 16'h00FF);
    $display("test two phase done");
    give_verdict;
  end
endmodule
